// ### hdl/audio_serial_pkg.sv
// What this block does
// - MSB first, width 16/20/24/32 selectable
// - Each clock separately master or slave
// - Word clock as pulse or square wave
// - Word clock runs at sample rate
// - Master bit clock from programmable divider
// - Slot mode off: both channels share offset
// - Slot mode: second offset after first word
// - Swap bit exchanges channel order
// - Bit clock polarity invert, all formats
// - Three-state after each channel LSB
// - Early three-state half bit sooner
// - Powered-down master: all pins released
// - Channel disables in left, I2S, DSP
// - Three-state off: idle data drives zero
// - Filter sync at earliest enabled channel
// - Both disabled: no data, sync at frame
// - Master clocks only with converter up, option
// - Pins routed to one of two hosts
// - Left, right, I2S, DSP, TDM formats
// - I2S MSB on second rising edge
// - DSP: left then right, falling edge
// - Right-justified LSB before word clock edge
// - Slot mode: only word clock rise frames
package audio_serial_pkg;

  typedef enum logic [1:0] {FMT_I2S, FMT_DSP, FMT_RJF, FMT_LJF} format_type;

  localparam logic [7:0] FMT_CTRL_ADDR   = 8'h1B;
  localparam logic [7:0] SLOT1_ADDR      = 8'h1C;
  localparam logic [7:0] POL_CTRL_ADDR   = 8'h1D;
  localparam logic [7:0] BCLK_DIV_ADDR   = 8'h1E;
  localparam logic [7:0] SLOT2_ADDR      = 8'h25;
  localparam logic [7:0] SLOT_CTRL_ADDR  = 8'h26;
  localparam logic [7:0] FRAME_LEN_ADDR  = 8'h40;
  localparam logic [7:0] POWER_ADDR      = 8'h41;
  localparam logic [7:0] STATUS_ADDR     = 8'h42;

  localparam int FMT_POS       = 6;
  localparam int WL_POS        = 4;
  localparam int BCLK_MST_BIT  = 3;
  localparam int WCLK_MST_BIT  = 2;
  localparam int TRISTATE_BIT  = 0;
  localparam int INVERT_BIT    = 3;
  localparam int KEEP_CLK_BIT  = 2;
  localparam int ROUTE_BIT     = 7;
  localparam int SWAP_BIT      = 4;
  localparam int DIS2_BIT      = 3;
  localparam int DIS1_BIT      = 2;
  localparam int EARLY_BIT     = 1;
  localparam int SLOT_BIT      = 0;
  localparam int ADC_PWR_BIT   = 0;
  localparam int PORT_PWR_BIT  = 1;
  localparam int PULSE_BIT     = 2;

  localparam logic [7:0] FMT_CTRL_RST  = 8'h00;
  localparam logic [7:0] SLOT_RST      = 8'h00;
  localparam logic [7:0] POL_CTRL_RST  = 8'h00;
  localparam logic [7:0] BCLK_DIV_RST  = 8'h01;
  localparam logic [7:0] SLOT_CTRL_RST = 8'h00;
  localparam logic [7:0] FRAME_LEN_RST = 8'h40;
  localparam logic [7:0] POWER_RST     = 8'h00;

  localparam logic [7:0] H_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] H_DIV_ADDR    = 8'h01;
  localparam logic [7:0] H_FRAME_ADDR  = 8'h02;
  localparam logic [7:0] H_START_ADDR  = 8'h03;
  localparam logic [7:0] H_LEN_ADDR    = 8'h04;
  localparam logic [7:0] H_STATUS_ADDR = 8'h05;
  localparam logic [7:0] H_RX_ADDR     = 8'h06;
  localparam int H_BCLK_BIT  = 0;
  localparam int H_WCLK_BIT  = 1;
  localparam int H_FALL_BIT  = 2;
  localparam int H_PULSE_BIT = 3;
  localparam logic [7:0] H_CTRL_RST  = 8'h00;
  localparam logic [7:0] H_DIV_RST   = 8'h01;
  localparam logic [7:0] H_FRAME_RST = 8'h40;
  localparam logic [7:0] H_START_RST = 8'h01;
  localparam logic [7:0] H_LEN_RST   = 8'h10;

  function automatic logic [5:0] word_len(input logic [1:0] code);
    case (code)
      2'h0:    word_len = 6'h10;
      2'h1:    word_len = 6'h14;
      2'h2:    word_len = 6'h18;
      default: word_len = 6'h20;
    endcase
  endfunction

endpackage

// ### hdl/audio_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface audio_link_if;
  logic dev_bclk;
  logic dev_bclk_oe;
  logic dev_wclk;
  logic dev_wclk_oe;
  logic dev_dout;
  logic dev_dout_oe;
  logic host_bclk;
  logic host_bclk_oe;
  logic host_wclk;
  logic host_wclk_oe;
  logic bclk;
  logic wclk;
  logic dout;

  // Undriven lines read low
  assign bclk = dev_bclk_oe ? dev_bclk : (host_bclk_oe & host_bclk);
  assign wclk = dev_wclk_oe ? dev_wclk : (host_wclk_oe & host_wclk);
  assign dout = dev_dout_oe & dev_dout;

  modport device (input bclk, wclk,
                  output dev_bclk, dev_bclk_oe, dev_wclk, dev_wclk_oe, dev_dout, dev_dout_oe);
  modport host   (input bclk, wclk, dout,
                  output host_bclk, host_bclk_oe, host_wclk, host_wclk_oe);
endinterface
`default_nettype wire

// ### hdl/adc_serial_device.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_device
  import audio_serial_pkg::*;
(
  input  wire logic        clk,          // 25 MHz clock
  input  wire logic        srst,         // Sync reset, high
  input  wire logic [7:0]  reg_addr,     // Register address
  input  wire logic [7:0]  reg_wdata,    // Register write data
  input  wire logic        reg_wr,       // Write strobe
  input  wire logic        reg_rd,       // Read strobe
  output logic      [7:0]  reg_rdata,    // Read data, next cycle
  input  wire logic [31:0] left_sample,  // Left conversion result
  input  wire logic [31:0] right_sample, // Right conversion result
  output logic             filter_sync,  // Filter sync pulse
  audio_link_if.device     link          // Serial audio pins
);

  logic [7:0]  fmt_q, off1_q, pol_q, div_q, off2_q, slot_q, frame_q, pwr_q;
  logic [7:0]  rdata_q, div_cnt_q, fcnt_q, fcnt_nx;
  logic        bclk_q, bclk_prev_q, wclk_q, wclk_last_q, wclk_now, wclk_gen;
  logic        bclk_oe_q, wclk_oe_q, dout_q, dout_oe_q, active_q, sync_q;
  logic [8:0]  pos_q, pos_nx, half_len_q, sa, sb;
  logic [5:0]  wl, left_q;
  logic [31:0] sh_q, first_smp, second_smp, lat_first_q, lat_second_q, aligned;
  logic        bclk_mst, wclk_mst, tri_en, invert, swap, dis1, dis2, early;
  logic        port_on, clk_run, slot_on, half_mode, dsp, i2s, rjf, en1, en2;
  logic        eff, prev_eff, rise, fall, launch, samp;
  logic        rise_ev, fall_ev, start_ev, first_half, frame_start;
  logic        load_a, load_b, load, bits_on;
  format_type  fmt;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fmt_q   <= FMT_CTRL_RST;
      off1_q  <= SLOT_RST;
      pol_q   <= POL_CTRL_RST;
      div_q   <= BCLK_DIV_RST;
      off2_q  <= SLOT_RST;
      slot_q  <= SLOT_CTRL_RST;
      frame_q <= FRAME_LEN_RST;
      pwr_q   <= POWER_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        FMT_CTRL_ADDR:  fmt_q   <= reg_wdata;
        SLOT1_ADDR:     off1_q  <= reg_wdata;
        POL_CTRL_ADDR:  pol_q   <= reg_wdata;
        BCLK_DIV_ADDR:  div_q   <= reg_wdata;
        SLOT2_ADDR:     off2_q  <= reg_wdata;
        SLOT_CTRL_ADDR: slot_q  <= reg_wdata;
        FRAME_LEN_ADDR: frame_q <= reg_wdata;
        POWER_ADDR:     pwr_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        FMT_CTRL_ADDR:  rdata_q <= fmt_q;
        SLOT1_ADDR:     rdata_q <= off1_q;
        POL_CTRL_ADDR:  rdata_q <= pol_q;
        BCLK_DIV_ADDR:  rdata_q <= div_q;
        SLOT2_ADDR:     rdata_q <= off2_q;
        SLOT_CTRL_ADDR: rdata_q <= slot_q;
        FRAME_LEN_ADDR: rdata_q <= frame_q;
        POWER_ADDR:     rdata_q <= pwr_q;
        STATUS_ADDR:    rdata_q <= {5'h00, active_q, dout_oe_q, bclk_oe_q};
        default:        rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign fmt      = format_type'(fmt_q[FMT_POS +: 2]);
  assign wl       = word_len(fmt_q[WL_POS +: 2]);
  assign bclk_mst = fmt_q[BCLK_MST_BIT];
  assign wclk_mst = fmt_q[WCLK_MST_BIT];
  assign tri_en   = fmt_q[TRISTATE_BIT];
  assign invert   = pol_q[INVERT_BIT];
  assign swap     = slot_q[SWAP_BIT];
  assign early    = slot_q[EARLY_BIT];
  assign dsp      = (fmt == FMT_DSP);
  assign i2s      = (fmt == FMT_I2S);
  assign rjf      = (fmt == FMT_RJF);
  // Channel disables are ignored in right-justified mode
  assign dis1     = slot_q[DIS1_BIT] & ~rjf;
  assign dis2     = slot_q[DIS2_BIT] & ~rjf;
  assign en1      = ~dis1;
  assign en2      = ~dis2;
  // Route bit set: this pin group belongs to the other host
  assign port_on  = pwr_q[PORT_PWR_BIT] & ~slot_q[ROUTE_BIT];
  assign clk_run  = port_on & (pwr_q[ADC_PWR_BIT] | pol_q[KEEP_CLK_BIT]);
  assign slot_on  = slot_q[SLOT_BIT] & ~rjf;
  assign half_mode = ~slot_on & ~dsp;

  // Master bit clock: half period of div_q system clocks
  always_ff @(posedge clk)
  begin
    if (srst || !clk_run || !bclk_mst)
    begin
      div_cnt_q <= 8'h00;
      bclk_q    <= 1'b0;
    end
    else if (div_cnt_q + 8'h01 >= div_q)
    begin
      div_cnt_q <= 8'h00;
      bclk_q    <= ~bclk_q;
    end
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  assign eff      = (bclk_mst ? bclk_q : link.bclk) ^ invert;
  assign prev_eff = bclk_prev_q ^ invert;
  assign rise     = eff & ~prev_eff;
  assign fall     = ~eff & prev_eff;
  assign launch   = dsp ? rise : fall;
  assign samp     = dsp ? fall : rise;

  always_ff @(posedge clk)
  begin
    if (srst)
      bclk_prev_q <= 1'b0;
    else
      bclk_prev_q <= bclk_mst ? bclk_q : link.bclk;
  end

  // Master word clock, one frame of frame_q bit clocks
  assign fcnt_nx  = (fcnt_q + 8'h01 >= frame_q) ? 8'h00 : fcnt_q + 8'h01;
  assign wclk_gen = pwr_q[PULSE_BIT] ? (fcnt_nx == 8'h00) : (fcnt_nx < {1'b0, frame_q[7:1]});
  assign wclk_now = wclk_mst ? wclk_gen : link.wclk;

  always_ff @(posedge clk)
  begin
    if (srst || !clk_run || !wclk_mst)
    begin
      fcnt_q <= 8'h00;
      wclk_q <= 1'b0;
    end
    else if (launch)
    begin
      fcnt_q <= fcnt_nx;
      wclk_q <= wclk_gen;
    end
  end

  assign rise_ev     = wclk_now & ~wclk_last_q;
  assign fall_ev     = ~wclk_now & wclk_last_q;
  assign start_ev    = rise_ev | (half_mode & fall_ev);
  assign pos_nx      = start_ev ? 9'h001 : ((pos_q == 9'h1FF) ? pos_q : pos_q + 9'h001);
  assign first_half  = i2s ? ~wclk_now : wclk_now;
  assign frame_start = half_mode ? (start_ev & first_half) : rise_ev;
  // Right-justified start uses the previous half length
  assign sa = rjf ? half_len_q - {3'h0, wl} + 9'h001
                  : {1'b0, off1_q} + (i2s ? 9'h002 : 9'h001);
  assign sb = sa + {3'h0, wl} + (slot_on ? {1'b0, off2_q} : 9'h000);
  assign load_a = (pos_nx == sa) & en1 & (~half_mode | first_half);
  assign load_b = en2 & (half_mode ? ((pos_nx == sa) & ~first_half) : (pos_nx == sb));
  assign load   = load_a | load_b;
  assign first_smp  = swap ? right_sample : left_sample;
  assign second_smp = swap ? left_sample : right_sample;
  assign aligned    = (load_a ? lat_first_q : lat_second_q) << (6'd32 - wl);
  assign bits_on    = load | (left_q != 6'h00);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wclk_last_q  <= 1'b0;
      pos_q        <= 9'h000;
      half_len_q   <= 9'h000;
      lat_first_q  <= 32'h00000000;
      lat_second_q <= 32'h00000000;
    end
    else if (launch)
    begin
      wclk_last_q <= wclk_now;
      pos_q       <= pos_nx;
      if (start_ev)
        half_len_q <= pos_q;
      if (frame_start)
      begin
        lat_first_q  <= first_smp;
        lat_second_q <= second_smp;
      end
    end
  end

  // Shifter, MSB first
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sh_q     <= 32'h00000000;
      left_q   <= 6'h00;
      dout_q   <= 1'b0;
      active_q <= 1'b0;
    end
    else if (launch)
    begin
      if (load)
      begin
        sh_q     <= aligned << 1;
        dout_q   <= aligned[31];
        left_q   <= wl - 6'h01;
        active_q <= 1'b1;
      end
      else if (left_q != 6'h00)
      begin
        sh_q     <= sh_q << 1;
        dout_q   <= sh_q[31];
        left_q   <= left_q - 6'h01;
        active_q <= 1'b1;
      end
      else
      begin
        dout_q   <= 1'b0;
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || !port_on)
      dout_oe_q <= 1'b0;
    else if (launch)
      dout_oe_q <= bits_on | ~tri_en;
    else if (samp && early && tri_en && left_q == 6'h00)
      dout_oe_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bclk_oe_q <= 1'b0;
      wclk_oe_q <= 1'b0;
    end
    else
    begin
      // Master pins released whenever port or clocks stop
      bclk_oe_q <= bclk_mst & clk_run;
      wclk_oe_q <= wclk_mst & clk_run;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      sync_q <= 1'b0;
    else
      sync_q <= launch & (load_a | (load_b & dis1) | (frame_start & dis1 & dis2));
  end

  assign reg_rdata        = rdata_q;
  assign filter_sync      = sync_q;
  assign link.dev_bclk    = bclk_q;
  assign link.dev_bclk_oe = bclk_oe_q;
  assign link.dev_wclk    = wclk_q;
  assign link.dev_wclk_oe = wclk_oe_q;
  assign link.dev_dout    = dout_q;
  assign link.dev_dout_oe = dout_oe_q;

endmodule
`default_nettype wire

// ### hdl/audio_serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module audio_serial_host
  import audio_serial_pkg::*;
(
  input  wire logic        clk,       // 25 MHz clock
  input  wire logic        srst,      // Sync reset, high
  input  wire logic [7:0]  reg_addr,  // Register address
  input  wire logic [7:0]  reg_wdata, // Register write data
  input  wire logic        reg_wr,    // Write strobe
  input  wire logic        reg_rd,    // Read strobe
  output logic      [7:0]  reg_rdata, // Read data, next cycle
  output logic      [31:0] rx_word,   // Last captured word
  output logic             rx_valid,  // Word captured pulse
  audio_link_if.host       link       // Serial audio pins
);

  logic [7:0]  ctrl_q, div_q, frame_q, start_q, len_q, rdata_q, div_cnt_q, fcnt_q, fcnt_nx;
  logic [8:0]  pos_q, pos_nx, last_pos;
  logic [31:0] sh_q, rx_q, sh_nx;
  logic        bclk_q, bclk_prev_q, wclk_q, wclk_last_q, ready_q, valid_q;
  logic        bclk_now, samp, change, done, status_rd, wclk_step;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q  <= H_CTRL_RST;
      div_q   <= H_DIV_RST;
      frame_q <= H_FRAME_RST;
      start_q <= H_START_RST;
      len_q   <= H_LEN_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        H_CTRL_ADDR:  ctrl_q  <= reg_wdata;
        H_DIV_ADDR:   div_q   <= reg_wdata;
        H_FRAME_ADDR: frame_q <= reg_wdata;
        H_START_ADDR: start_q <= reg_wdata;
        H_LEN_ADDR:   len_q   <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign status_rd = reg_rd & (reg_addr == H_STATUS_ADDR);

  always_ff @(posedge clk)
  begin
    if (srst || !reg_rd)
      rdata_q <= 8'h00;
    else
    begin
      case (reg_addr)
        H_CTRL_ADDR:       rdata_q <= ctrl_q;
        H_DIV_ADDR:        rdata_q <= div_q;
        H_FRAME_ADDR:      rdata_q <= frame_q;
        H_START_ADDR:      rdata_q <= start_q;
        H_LEN_ADDR:        rdata_q <= len_q;
        H_STATUS_ADDR:     rdata_q <= {7'h00, ready_q};
        H_RX_ADDR:         rdata_q <= rx_q[7:0];
        H_RX_ADDR + 8'h01: rdata_q <= rx_q[15:8];
        H_RX_ADDR + 8'h02: rdata_q <= rx_q[23:16];
        H_RX_ADDR + 8'h03: rdata_q <= rx_q[31:24];
        default:           rdata_q <= 8'h00;
      endcase
    end
  end

  // Clocks this end supplies when the device is slave
  always_ff @(posedge clk)
  begin
    if (srst || !ctrl_q[H_BCLK_BIT])
    begin
      div_cnt_q <= 8'h00;
      bclk_q    <= 1'b0;
    end
    else if (div_cnt_q + 8'h01 >= div_q)
    begin
      div_cnt_q <= 8'h00;
      bclk_q    <= ~bclk_q;
    end
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  assign bclk_now = link.bclk;
  assign samp     = ctrl_q[H_FALL_BIT] ? (~bclk_now & bclk_prev_q) : (bclk_now & ~bclk_prev_q);
  assign change   = bclk_now != bclk_prev_q;
  assign fcnt_nx  = (fcnt_q + 8'h01 >= frame_q) ? 8'h00 : fcnt_q + 8'h01;
  // Own bit clock: step with the toggle itself, so the far end sees both edges together
  assign wclk_step = ctrl_q[H_BCLK_BIT] ? ((div_cnt_q + 8'h01 >= div_q) && (bclk_q ^ ctrl_q[H_FALL_BIT]))
                                        : (change && !samp);

  // Word clock moves on the edge opposite to sampling
  always_ff @(posedge clk)
  begin
    if (srst || !ctrl_q[H_WCLK_BIT])
    begin
      fcnt_q <= 8'h00;
      wclk_q <= 1'b0;
    end
    else if (wclk_step)
    begin
      fcnt_q <= fcnt_nx;
      wclk_q <= ctrl_q[H_PULSE_BIT] ? (fcnt_nx == 8'h00) : (fcnt_nx < {1'b0, frame_q[7:1]});
    end
  end

  // Capture window counted from word clock rise
  assign pos_nx   = (link.wclk & ~wclk_last_q) ? 9'h001 : ((pos_q == 9'h1FF) ? pos_q : pos_q + 9'h001);
  assign last_pos = {1'b0, start_q} + {1'b0, len_q} - 9'h001;
  assign sh_nx    = {sh_q[30:0], link.dout};
  assign done     = samp & (pos_nx == last_pos);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bclk_prev_q <= 1'b0;
      wclk_last_q <= 1'b0;
      pos_q       <= 9'h000;
      sh_q        <= 32'h00000000;
      rx_q        <= 32'h00000000;
      valid_q     <= 1'b0;
    end
    else
    begin
      bclk_prev_q <= bclk_now;
      valid_q     <= done;
      if (samp)
      begin
        wclk_last_q <= link.wclk;
        pos_q       <= pos_nx;
        if (pos_nx >= {1'b0, start_q} && pos_nx <= last_pos)
          sh_q <= sh_nx;
      end
      if (done)
        rx_q <= sh_nx;
    end
  end

  // New word wins over a status read in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      ready_q <= 1'b0;
    else if (done)
      ready_q <= 1'b1;
    else if (status_rd)
      ready_q <= 1'b0;
  end

  assign reg_rdata         = rdata_q;
  assign rx_word           = rx_q;
  assign rx_valid          = valid_q;
  assign link.host_bclk    = bclk_q;
  assign link.host_bclk_oe = ctrl_q[H_BCLK_BIT];
  assign link.host_wclk    = wclk_q;
  assign link.host_wclk_oe = ctrl_q[H_WCLK_BIT];

endmodule
`default_nettype wire

// ### testbench/adc_audio_serial_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_audio_serial_port_checker (
  input wire logic clk,          // Clock
  input wire logic srst,         // Sync reset
  input wire logic bclk,         // Resolved bit clock
  input wire logic dev_wclk,     // Device word clock
  input wire logic dev_bclk_oe,  // Device bit clock drive
  input wire logic dev_wclk_oe,  // Device word clock drive
  input wire logic dev_dout,     // Device data
  input wire logic dev_dout_oe,  // Device data drive
  input wire logic host_bclk_oe, // Host bit clock drive
  input wire logic host_wclk_oe  // Host word clock drive
);
  localparam int MIN_RUN = 24;
  logic       b1_q;
  logic       b2_q;
  logic       b3_q;
  logic [7:0] run_q;
  logic       edge_seen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Pin registers lag the clock edge by one or two cycles
  always_ff @(posedge clk)
  begin
    b1_q <= bclk;
    b2_q <= b1_q;
    b3_q <= b2_q;
  end
  assign edge_seen = (bclk != b1_q) || (b1_q != b2_q) || (b2_q != b3_q);

  always_ff @(posedge clk)
    if (srst || !dev_dout_oe)
      run_q <= 8'h00;
    else if (run_q != 8'hFF)
      run_q <= run_q + 8'h01;

  property p_reset_release;
    @(posedge clk) disable iff (1'b0) srst |-> ##1 !(dev_bclk_oe | dev_wclk_oe | dev_dout_oe);
  endproperty
  property p_one_bclk_driver;
    !(dev_bclk_oe && host_bclk_oe);
  endproperty
  property p_one_wclk_driver;
    !(dev_wclk_oe && host_wclk_oe);
  endproperty
  property p_dout_on_edge;
    dev_dout_oe && $past(dev_dout_oe) && $changed(dev_dout) |-> edge_seen;
  endproperty
  property p_wclk_on_edge;
    dev_wclk_oe && $past(dev_wclk_oe) && $changed(dev_wclk) |-> edge_seen;
  endproperty
  property p_word_run;
    $fell(dev_dout_oe) |-> run_q >= MIN_RUN;
  endproperty
  property p_release_all;
    $fell(dev_bclk_oe) |-> !dev_dout_oe;
  endproperty
  property p_wclk_high_hold;
    $rose(dev_wclk) && dev_wclk_oe |=> dev_wclk || !dev_wclk_oe;
  endproperty

  a_reset_release: assert property (p_reset_release) else $error("pins driven after reset");
  a_one_bclk_driver: assert property (p_one_bclk_driver) else $error("bit clock driven twice");
  a_one_wclk_driver: assert property (p_one_wclk_driver) else $error("word clock driven twice");
  a_dout_on_edge: assert property (p_dout_on_edge) else $error("data moved off a clock edge");
  a_wclk_on_edge: assert property (p_wclk_on_edge) else $error("word clock moved off an edge");
  a_word_run: assert property (p_word_run) else $error("data released before word end");
  a_release_all: assert property (p_release_all) else $error("data left driven after clock release");
  a_wclk_high_hold: assert property (p_wclk_high_hold) else $error("word clock high one cycle");

  c_release: cover property ($fell(dev_dout_oe));
  c_frame: cover property ($rose(dev_wclk) && dev_wclk_oe);
  c_host_clock: cover property (host_bclk_oe && $rose(bclk));
endmodule
`default_nettype wire

// ### testbench/adc_audio_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_audio_serial_port_tb;
  import audio_serial_pkg::*;
  localparam logic [7:0] DEV_A [8] = '{FMT_CTRL_ADDR, SLOT1_ADDR, POL_CTRL_ADDR, BCLK_DIV_ADDR,
                                       SLOT2_ADDR, SLOT_CTRL_ADDR, FRAME_LEN_ADDR, POWER_ADDR};
  localparam logic [7:0] DEV_R [8] = '{FMT_CTRL_RST, SLOT_RST, POL_CTRL_RST, BCLK_DIV_RST,
                                       SLOT_RST, SLOT_CTRL_RST, FRAME_LEN_RST, POWER_RST};
  localparam logic [7:0] HST_A [5] = '{H_CTRL_ADDR, H_DIV_ADDR, H_FRAME_ADDR, H_START_ADDR, H_LEN_ADDR};
  localparam logic [7:0] HST_R [5] = '{H_CTRL_RST, H_DIV_RST, H_FRAME_RST, H_START_RST, H_LEN_RST};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  d_addr = 8'h00;
  logic [7:0]  d_wdata = 8'h00;
  logic        d_wr = 1'b0;
  logic        d_rd = 1'b0;
  logic [7:0]  d_rdata;
  logic [7:0]  h_addr = 8'h00;
  logic [7:0]  h_wdata = 8'h00;
  logic        h_wr = 1'b0;
  logic        h_rd = 1'b0;
  logic [7:0]  h_rdata;
  logic [31:0] left_sample = 32'h0;
  logic [31:0] right_sample = 32'h0;
  logic        filter_sync;
  logic [31:0] rx_word;
  logic        rx_valid;
  logic        rd_seen = 1'b0;
  logic        rd_host = 1'b0;
  logic        b;
  int          j;
  int          err_count = 0;
  int          n_compared = 0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [31:0] rd_q[$];

  always #20 clk = ~clk;

  audio_link_if u_audio_link_if ();
  adc_serial_device u_adc_serial_device (.clk(clk), .srst(srst), .reg_addr(d_addr), .reg_wdata(d_wdata),
    .reg_wr(d_wr), .reg_rd(d_rd), .reg_rdata(d_rdata), .left_sample(left_sample),
    .right_sample(right_sample), .filter_sync(filter_sync), .link(u_audio_link_if.device));
  audio_serial_host u_audio_serial_host (.clk(clk), .srst(srst), .reg_addr(h_addr), .reg_wdata(h_wdata),
    .reg_wr(h_wr), .reg_rd(h_rd), .reg_rdata(h_rdata), .rx_word(rx_word), .rx_valid(rx_valid),
    .link(u_audio_link_if.host));
  adc_audio_serial_port_checker u_adc_audio_serial_port_checker (.clk(clk), .srst(srst),
    .bclk(u_audio_link_if.bclk), .dev_wclk(u_audio_link_if.dev_wclk),
    .dev_bclk_oe(u_audio_link_if.dev_bclk_oe), .dev_wclk_oe(u_audio_link_if.dev_wclk_oe),
    .dev_dout(u_audio_link_if.dev_dout), .dev_dout_oe(u_audio_link_if.dev_dout_oe),
    .host_bclk_oe(u_audio_link_if.host_bclk_oe), .host_wclk_oe(u_audio_link_if.host_wclk_oe));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Address goes to both ends, only the chosen strobe rises
  task automatic bus(input bit host, input bit rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    d_addr <= a;
    h_addr <= a;
    d_wdata <= d;
    h_wdata <= d;
    d_wr <= !host && !rd;
    d_rd <= !host && rd;
    h_wr <= host && !rd;
    h_rd <= host && rd;
    @(posedge clk);
    d_wr <= 1'b0;
    d_rd <= 1'b0;
    h_wr <= 1'b0;
    h_rd <= 1'b0;
  endtask

  task automatic rd_chk(input bit host, input logic [7:0] a, input logic [7:0] d);
    rd_q.push_back({24'h0, d});
    bus(host, 1'b1, a, 8'h00);
  endtask

  // Pick: 0 left, 1 right, 2 silent line
  task automatic frame_case(input logic [7:0] fmt, slot, off1, off2, pol, hctl, hst,
                            input int wl, input int pick);
    logic [31:0] m;
    m = (wl == 32) ? 32'hFFFFFFFF : ((32'h1 << wl) - 32'h1);
    @(posedge clk);
    left_sample <= $urandom();
    right_sample <= $urandom();
    bus(0, 0, SLOT_CTRL_ADDR, slot);
    bus(0, 0, SLOT1_ADDR, off1);
    bus(0, 0, SLOT2_ADDR, off2);
    bus(0, 0, POL_CTRL_ADDR, pol);
    bus(0, 0, FMT_CTRL_ADDR, fmt);
    bus(1, 0, H_CTRL_ADDR, hctl);
    bus(1, 0, H_START_ADDR, hst);
    bus(1, 0, H_LEN_ADDR, wl[7:0]);
    bus(0, 0, POWER_ADDR, 8'h03);
    // Let frames under the old setup drain out
    repeat (1600) @(posedge clk);
    mask_q.push_back(m);
    exp_q.push_back(pick == 0 ? left_sample & m : (pick == 1 ? right_sample & m : 32'h0));
    for (int i = 0; i < 1200 && exp_q.size() > 0; i++)
      @(posedge clk);
    check("rx words outstanding", exp_q.size(), 32'h0);
    exp_q.delete();
    mask_q.delete();
    $display("case fmt %h slot %h done", fmt, slot);
  endtask

  always @(posedge clk)
  begin
    if (rd_seen)
      check("reg_rdata", rd_host ? {24'h0, h_rdata} : {24'h0, d_rdata}, rd_q.pop_front());
    rd_seen = d_rd | h_rd;
    rd_host = h_rd;
    if (rx_valid === 1'b1 && exp_q.size() > 0)
      check("rx_word", rx_word & mask_q.pop_front(), exp_q.pop_front());
    if (filter_sync === 1'b1 && exp_q.size() > 0)
      check("filter_sync", {31'h0, u_audio_link_if.dev_dout_oe}, 32'h1);
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("MISMATCH run length expected end seen watchdog");
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'hA25B));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (DEV_A[i])
      rd_chk(0, DEV_A[i], DEV_R[i]);
    foreach (HST_A[i])
      rd_chk(1, HST_A[i], HST_R[i]);
    bus(0, 0, 8'h7F, 8'hAA);
    rd_chk(0, 8'h7F, 8'h00);
    bus(0, 0, BCLK_DIV_ADDR, 8'h04);
    rd_chk(0, BCLK_DIV_ADDR, 8'h04);
    $display("register test done");
    frame_case(8'hCC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 16, 0);
    @(negedge clk);
    b = u_audio_link_if.bclk;
    for (j = 0; j < 50 && u_audio_link_if.bclk === b; j++)
      @(negedge clk);
    b = u_audio_link_if.bclk;
    for (j = 0; j < 50 && u_audio_link_if.bclk === b; j++)
      @(negedge clk);
    check("bclk half period", j, 32'd4);
    frame_case(8'hCC, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 16, 1);
    frame_case(8'hCC, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04, 16, 0);
    frame_case(8'h2C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 24, 1);
    frame_case(8'h5C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'd21, 20, 1);
    frame_case(8'hCC, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'd18, 16, 1);
    frame_case(8'hFC, 8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'h01, 32, 0);
    frame_case(8'h4C, 8'h11, 8'h02, 8'h03, 8'h00, 8'h04, 8'd22, 16, 0);
    frame_case(8'hCD, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 16, 2);
    frame_case(8'h8C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'd17, 16, 0);
    bus(0, 0, POWER_ADDR, 8'h01);
    repeat (6) @(negedge clk);
    check("pin drive off", {29'h0, u_audio_link_if.dev_bclk_oe, u_audio_link_if.dev_wclk_oe,
          u_audio_link_if.dev_dout_oe}, 32'h0);
    bus(0, 0, POWER_ADDR, 8'h03);
    bus(0, 0, SLOT_CTRL_ADDR, 8'h80);
    repeat (6) @(negedge clk);
    check("pin drive routed", {29'h0, u_audio_link_if.dev_bclk_oe, u_audio_link_if.dev_wclk_oe,
          u_audio_link_if.dev_dout_oe}, 32'h0);
    $display("power and routing test done");
    // Clocks change hands only while the port is down
    bus(0, 0, POWER_ADDR, 8'h01);
    bus(1, 0, H_DIV_ADDR, 8'h04);
    frame_case(8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 16, 0);
    rd_chk(1, H_STATUS_ADDR, 8'h01);
    rd_chk(1, H_RX_ADDR, left_sample[7:0]);
    repeat (2) @(posedge clk);
    $display("host readback test done");
    give_verdict();
  end
endmodule
`default_nettype wire
